// ### include/cctc_pkg.sv
// cctc_pkg: constants and carriers for the capture/compare timer channels
// assumes one 100 MHz clock; register byte address is four times the index
package cctc_pkg;

  localparam int NCH_MAX = 8;

  // register indices
  localparam logic [5:0] IDX_DIR = 6'h00;
  localparam logic [5:0] IDX_FORCE = 6'h01;
  localparam logic [5:0] IDX_CNT = 6'h04;
  localparam logic [5:0] IDX_CTL1 = 6'h06;
  localparam logic [5:0] IDX_OMOL = 6'h09;
  localparam logic [5:0] IDX_EDGE = 6'h0B;
  localparam logic [5:0] IDX_IE = 6'h0C;
  localparam logic [5:0] IDX_CTL2 = 6'h0D;
  localparam logic [5:0] IDX_FLAG = 6'h0E;
  localparam logic [5:0] IDX_VAL0 = 6'h10;
  localparam logic [5:0] IDX_PD = 6'h2C;
  localparam logic [5:0] IDX_PTPS = 6'h2E;
  localparam logic [5:0] IDX_PORT = 6'h30;

  // field positions
  localparam int CTL1_TEN = 7;
  localparam int CTL1_PRECISION_PRESCALE_SELECT = 3;
  localparam int CTL2_PR_LSB = 0;

  // reset values
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [7:0] REG_RST = 8'h00;

  // per-channel control carrier
  typedef struct packed {
    logic dir;
    logic om;
    logic ol;
    logic [1:0] edge_sel;
    logic pd;
    logic ie;
  } cctc_ctl_s;

  // channel state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] value;
    logic flag;
    logic oc;
  } cctc_chan_s;

  // timer state
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] ie;
    logic [7:0] pd;
    logic [7:0] ptps;
    logic [7:0] port;
    logic timer_run_enable;
    logic precision_prescale_select;
    logic [2:0] pr;
    logic [15:0] omol;
    logic [15:0] edge_sel;
    logic [15:0] counter;
    logic [7:0] pre;
    logic [7:0] lim;
    logic step;
    logic done;
    logic [31:0] rdata;
  } cctc_main_s;

endpackage : cctc_pkg

// ### design/cctc_channel.sv
// cctc_channel: one capture/compare channel with its pin logic
// assumes counter and step come from the timer on the same clock
`timescale 1ns/1ns
module cctc_channel
  import cctc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pin_in,
  input wire cctc_ctl_s ctl,
  input wire logic timer_run_enable,
  input wire logic [15:0] counter,
  input wire logic step,
  input wire logic wr_val,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  input wire logic clr,
  input wire logic force_cmp,
  input wire logic port_bit,
  output logic [15:0] value,
  output logic flag,
  output logic pin_out,
  output logic pin_oe_n,
  output logic irq
);

  cctc_chan_s st;
  cctc_chan_s nx;
  logic rise;
  logic fall;
  logic cap;
  logic match;

  always_comb begin
    nx = st;
    nx.s1 = pin_in;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    rise = st.s2 & ~st.s3;
    fall = ~st.s2 & st.s3;
    cap = ~ctl.dir & ((ctl.edge_sel[0] & rise) | (ctl.edge_sel[1] & fall));
    match = ctl.dir & step & (counter == st.value);
    if (cap) begin
      nx.value = counter;
    end else if (ctl.dir & wr_val) begin
      // capture channels ignore writes
      if (wr_be[0]) nx.value[7:0] = wr_data[7:0];
      if (wr_be[1]) nx.value[15:8] = wr_data[15:8];
    end
    if (match | (ctl.dir & force_cmp)) begin
      case ({ctl.om, ctl.ol})
        2'b01: nx.oc = ~st.oc;
        2'b10: nx.oc = 1'b0;
        2'b11: nx.oc = 1'b1;
        default: nx.oc = st.oc;
      endcase
    end
    // a new event beats a clear in the same cycle
    nx.flag = cap | match | (st.flag & ~(clr & timer_run_enable));
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign value = st.value;
  assign flag = st.flag;
  assign irq = st.flag & ctl.ie;
  // port latch shows whenever the timer does not own the pin
  assign pin_out = (ctl.dir & (ctl.om | ctl.ol) & ~ctl.pd) ? st.oc : port_bit;
  assign pin_oe_n = ~ctl.dir;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_cap;
    cap;
  endsequence

  property p_capture;
    @(posedge clock) disable iff (sys_rst) s_cap |=> value == $past(counter);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_flag_set;
    @(posedge clock) disable iff (sys_rst) (cap || match) |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_wr_ign;
    @(posedge clock) disable iff (sys_rst) (wr_val && !ctl.dir && !cap) |=> $stable(value);
  endproperty
  a_wr_ign: assert property (p_wr_ign) else $error("capture value written");

  property p_force;
    @(posedge clock) disable iff (sys_rst) (force_cmp && !flag && !cap && !match) |=> !flag;
  endproperty
  a_force: assert property (p_force) else $error("force set flag");

  property p_clear;
    @(posedge clock) disable iff (sys_rst) (flag && clr && !timer_run_enable) |=> flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag cleared with timer off");

  property p_pd_pin;
    @(posedge clock) disable iff (sys_rst) ctl.pd |-> pin_out == port_bit;
  endproperty
  a_pd_pin: assert property (p_pd_pin) else $error("disconnected pin moved");

  property p_noact;
    @(posedge clock) disable iff (sys_rst) (match && !ctl.om && !ctl.ol) |=> $stable(st.oc);
  endproperty
  a_noact: assert property (p_noact) else $error("pin changed without action");

endmodule : cctc_channel

// ### design/cctc_timer.sv
// cctc_timer: 16-bit timer with capture/compare channels, Avalon-MM slave
// assumes pins are asynchronous and software follows the bus timing below
//
// Contract
// - value register latches counter on capture, is match value on compare
// - value writes work in compare mode, ignored in capture mode
// - all value registers reset to zero
// - absent channel value registers ignore writes and read zero
// - disconnect bit zero lets compare action reach pin; never affects capture
// - disconnect bit one blocks pin action but flag still sets
// - disconnect bits reset zero, read/write anytime, absent bits read zero
// - precision select set: divide bus clock by divider field plus one
// - new prescale factor applies only when prescale counter wraps to zero, or at once while the timer is stopped
// - precision select clear: coarse field divides by power of two to 128
// - direction clear means capture; active edge copies counter to value
// - capture sets flag; interrupt request only while enable bit set
// - writing one clears flag only while timer enabled
// - direction set means compare; equality sets flag and applies action
// - mode and level both zero leave pin unchanged
// - mode/level: 01 toggle, 10 low, 11 high
// - force bit applies compare action at once without setting flag, only while timer enabled
// - port writes go to a latch shown when pin is general purpose
// - edge select: 00 off, 01 rising, 10 falling, 11 both
`timescale 1ns/1ns
module cctc_timer
  import cctc_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_CH-1:0] pin_in,
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe_n,
  output logic [NUM_CH-1:0] chan_irq
);

  localparam logic [7:0] CH_MASK = 8'((1 << NUM_CH) - 1);
  localparam logic [15:0] PAIR_MASK = 16'((1 << (2 * NUM_CH)) - 1);

  cctc_main_s st;
  cctc_main_s nx;
  logic [5:0] idx;
  logic req;
  logic wacc;
  logic wlo;
  logic whi;
  logic tick;
  logic [7:0] lim_new;
  logic [7:0] wd8;
  logic [31:0] rd;
  logic [15:0] ch_val [NCH_MAX];
  logic [NCH_MAX-1:0] ch_flag;
  logic [NCH_MAX-1:0] clr_vec;
  logic [NCH_MAX-1:0] force_vec;
  logic [NCH_MAX-1:0] wval_vec;

  assign idx = avs_address[7:2];
  assign req = avs_read | avs_write;
  assign wacc = avs_write & st.done;
  assign wlo = wacc & avs_byteenable[0];
  assign whi = wacc & avs_byteenable[1];
  assign wd8 = avs_writedata[7:0];
  assign tick = st.pre == st.lim;

  ////////////////////////////////////////////////////////////////////////////
  // write pulses toward the channels
  always_comb begin
    clr_vec = '0;
    force_vec = '0;
    wval_vec = '0;
    for (int i = 0; i < NCH_MAX; i++) begin
      if (wlo && idx == IDX_FLAG) begin
        clr_vec[i] = wd8[i] & CH_MASK[i];
      end
      if (wlo && idx == IDX_FORCE) begin
        force_vec[i] = wd8[i] & CH_MASK[i] & st.timer_run_enable;
      end
      if (idx == IDX_VAL0 + 6'(2 * i)) begin
        wval_vec[i] = wacc & CH_MASK[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  always_comb begin
    rd = 32'h0000_0000;
    case (idx)
      IDX_DIR: rd[7:0] = st.dir;
      IDX_CNT: rd[15:0] = st.counter;
      IDX_CTL1: begin
        rd[CTL1_TEN] = st.timer_run_enable;
        rd[CTL1_PRECISION_PRESCALE_SELECT] = st.precision_prescale_select;
      end
      IDX_OMOL: rd[15:0] = st.omol;
      IDX_EDGE: rd[15:0] = st.edge_sel;
      IDX_IE: rd[7:0] = st.ie;
      IDX_CTL2: rd[CTL2_PR_LSB +: 3] = st.pr;
      IDX_FLAG: rd[7:0] = ch_flag & CH_MASK;
      IDX_PD: rd[7:0] = st.pd;
      IDX_PTPS: rd[7:0] = st.ptps;
      IDX_PORT: rd[7:0] = st.port;
      default: begin
        // value registers; absent ones read zero
        if (idx[5:4] == 2'b01 && !idx[0]) begin
          rd[15:0] = ch_val[idx[3:1]];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nx = st;
    // one wait cycle per request; read data registered in that cycle
    nx.done = req & ~st.done;
    if (req && !st.done) begin
      nx.rdata = rd;
    end
    nx.step = 1'b0;
    if (st.precision_prescale_select) begin
      lim_new = st.ptps;
    end else begin
      lim_new = 8'((9'h001 << st.pr) - 9'h001);
    end
    if (!st.timer_run_enable) begin
      nx.pre = 8'h00;
      nx.lim = lim_new;
    end else if (tick) begin
      // divisor reloads only at the all-zero point
      nx.pre = 8'h00;
      nx.lim = lim_new;
      nx.counter = st.counter + 16'h0001;
      nx.step = 1'b1;
    end else begin
      nx.pre = st.pre + 8'h01;
    end
    if (wlo) begin
      case (idx)
        IDX_DIR: nx.dir = wd8 & CH_MASK;
        IDX_CTL1: begin
          nx.timer_run_enable = wd8[CTL1_TEN];
          nx.precision_prescale_select = wd8[CTL1_PRECISION_PRESCALE_SELECT];
        end
        IDX_OMOL: nx.omol[7:0] = wd8 & PAIR_MASK[7:0];
        IDX_EDGE: nx.edge_sel[7:0] = wd8 & PAIR_MASK[7:0];
        IDX_IE: nx.ie = wd8 & CH_MASK;
        IDX_CTL2: nx.pr = wd8[CTL2_PR_LSB +: 3];
        IDX_PD: nx.pd = wd8 & CH_MASK;
        IDX_PTPS: nx.ptps = wd8;
        IDX_PORT: nx.port = wd8 & CH_MASK;
        default: nx.pr = st.pr;
      endcase
    end
    if (whi) begin
      case (idx)
        IDX_OMOL: nx.omol[15:8] = avs_writedata[15:8] & PAIR_MASK[15:8];
        IDX_EDGE: nx.edge_sel[15:8] = avs_writedata[15:8] & PAIR_MASK[15:8];
        default: nx.pr = nx.pr;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = req & ~st.done;

  ////////////////////////////////////////////////////////////////////////////
  // channels
  for (genvar g = 0; g < NCH_MAX; g++) begin : g_ch
    if (g < NUM_CH) begin : g_on
      cctc_ctl_s ctl;
      logic [15:0] val;
      logic flg;
      assign ctl.dir = st.dir[g];
      assign ctl.om = st.omol[2 * g + 1];
      assign ctl.ol = st.omol[2 * g];
      assign ctl.edge_sel = st.edge_sel[2 * g +: 2];
      assign ctl.pd = st.pd[g];
      assign ctl.ie = st.ie[g];
      cctc_channel u_ch (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(pin_in[g]),
        .ctl(ctl),
        .timer_run_enable(st.timer_run_enable),
        .counter(st.counter),
        .step(st.step),
        .wr_val(wval_vec[g]),
        .wr_be(avs_byteenable[1:0]),
        .wr_data(avs_writedata[15:0]),
        .clr(clr_vec[g]),
        .force_cmp(force_vec[g]),
        .port_bit(st.port[g]),
        .value(val),
        .flag(flg),
        .pin_out(pin_out[g]),
        .pin_oe_n(pin_oe_n[g]),
        .irq(chan_irq[g])
      );
      assign ch_val[g] = val;
      assign ch_flag[g] = flg;
    end else begin : g_off
      assign ch_val[g] = VAL_RST;
      assign ch_flag[g] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_hold;
    @(posedge clock) disable iff (sys_rst) !st.timer_run_enable |=> st.counter == $past(st.counter);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while disabled");

  property p_step;
    @(posedge clock) disable iff (sys_rst)
      (st.timer_run_enable && tick) |=> st.counter == $past(st.counter) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("counter missed a tick");

  property p_lim;
    @(posedge clock) disable iff (sys_rst) $changed(st.lim) |-> st.pre == 8'h00;
  endproperty
  a_lim: assert property (p_lim) else $error("divisor changed mid count");

  sequence s_reload;
    st.timer_run_enable && tick;
  endsequence

  property p_prec;
    @(posedge clock) disable iff (sys_rst)
      (s_reload and st.precision_prescale_select) |=> st.lim == $past(st.ptps);
  endproperty
  a_prec: assert property (p_prec) else $error("precision divisor wrong");

  property p_coarse;
    @(posedge clock) disable iff (sys_rst)
      (s_reload and !st.precision_prescale_select) |=> st.lim == 8'((9'h001 << $past(st.pr)) - 9'h001);
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse divisor wrong");

  property p_pd_wr;
    @(posedge clock) disable iff (sys_rst)
      (wlo && idx == IDX_PD) |=> st.pd == ($past(wd8) & CH_MASK);
  endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("disconnect write wrong");

  sequence s_pend;
    req && avs_waitrequest;
  endsequence

  property p_wait;
    @(posedge clock) disable iff (sys_rst) s_pend |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("request not answered");

endmodule : cctc_timer

// ### bench/cctc_pins.sv
// cctc_pins: event source and load on the channel pins
// assumes one bench clock; wire level resolved from the device enables
`timescale 1ns/1ns
module cctc_pins
  import cctc_pkg::*;
(
  input wire logic clock,
  input wire logic [1:0] level_req,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  output logic [1:0] pin_in
);
  logic [1:0] src = 2'b00;
  integer hold = 0;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (hold > 0) begin
      hold <= hold - 1;
    end else if (src != level_req) begin
      src <= level_req;
      hold <= 4;
    end
  end
  // device drives the wire where its enable is low
  assign pin_in = (pin_oe_n & src) | (~pin_oe_n & pin_out);
endmodule : cctc_pins

// ### bench/cctc_timer_bench.sv
// cctc_timer_bench: self-checking bench for the timer channels
// assumes two channels, Avalon master tasks and the pin model
`timescale 1ns/1ns
module cctc_timer_bench;
  import cctc_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] pin_in, pin_out, pin_oe_n, chan_irq;
  logic [1:0] lvl = 2'b00;
  logic [31:0] q;
  logic [15:0] cv, t0, cap;
  logic [2:0] tbl [6];
  integer fails = 0;
  integer tests_run = 0;
  integer seed = 98344;
  integer i, n, e, dv, ex, d;
  logic exp_pin, exp_f;
  cctc_timer #(.NUM_CH(2)) uut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .chan_irq(chan_irq));
  cctc_pins pins (.clock(clock), .level_req(lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clock = ~clock;
  end
  task chk(input string nm, input logic [31:0] ev, input logic [31:0] sv);
    tests_run++;
    if (sv !== ev) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ev, sv);
    end
  endtask : chk
  task bus(input logic w, input logic [5:0] idx, input logic [15:0] dat, input logic [3:0] be);
    @(posedge clock);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0, dat};
    avs_byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) chk("waitrequest", 0, 1);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // accepted access settles before callers look at outputs
    @(negedge clock);
  endtask : bus
  task rdc(input string nm, input logic [5:0] idx, input logic [31:0] ev);
    bus(1'b0, idx, 16'h0, 4'h3);
    chk(nm, ev, q);
  endtask : rdc
  task wait_match();
    bus(1'b0, IDX_CNT, 16'h0, 4'h3);
    cv = q[15:0] + 16'd30 + 16'($random(seed) & 31);
    bus(1'b1, IDX_VAL0, cv, 4'h2);
    bus(1'b1, IDX_VAL0, cv, 4'h1);
    bus(1'b1, IDX_FLAG, 16'h0001, 4'h1);
    rdc("val0", IDX_VAL0, {16'h0, cv});
    for (i = 0; i < 60; i++) begin
      bus(1'b0, IDX_FLAG, 16'h0, 4'h1);
      if (q[0] === 1'b1) break;
    end
    chk("flag0", 1, q[0]);
  endtask : wait_match
  task wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #500000;
    fails++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tbl = '{3'b001, 3'b001, 3'b011, 3'b010, 3'b000, 3'b111};
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rdc("val0 rst", IDX_VAL0, 0);
    rdc("val1 rst", IDX_VAL0 + 6'h2, 0);
    rdc("pd rst", IDX_PD, 0);
    rdc("unmapped", 6'h3F, 0);
    chk("oe rst", 2'b11, pin_oe_n);
    bus(1'b1, IDX_PD, 16'h00FF, 4'h1);
    rdc("pd bits", IDX_PD, 32'h3);
    bus(1'b1, IDX_PD, 16'h0000, 4'h1);
    bus(1'b1, IDX_VAL0 + 6'h4, 16'h1234, 4'h3);
    rdc("absent val", IDX_VAL0 + 6'h4, 0);
    $display("test registers done");
    // compare actions on channel 0
    exp_pin = 1'b0;
    bus(1'b1, IDX_DIR, 16'h0001, 4'h1);
    bus(1'b1, IDX_CTL1, 16'h0080, 4'h1);
    for (e = 0; e < 6; e++) begin
      bus(1'b1, IDX_OMOL, {14'h0, tbl[e][1:0]}, 4'h1);
      bus(1'b1, IDX_PD, {15'h0, tbl[e][2]}, 4'h1);
      wait_match();
      if (!tbl[e][2] && tbl[e][1:0] == 2'b01) exp_pin = ~exp_pin;
      if (!tbl[e][2] && tbl[e][1]) exp_pin = tbl[e][0];
      chk("cmp pin", exp_pin, pin_out[0]);
      chk("cmp oe", 0, pin_oe_n[0]);
      chk("irq0 off", 0, chan_irq[0]);
    end
    bus(1'b1, IDX_PD, 16'h0000, 4'h1);
    bus(1'b1, IDX_OMOL, 16'h0003, 4'h1);
    bus(1'b1, IDX_FLAG, 16'h0001, 4'h1);
    bus(1'b1, IDX_FORCE, 16'h0001, 4'h1);
    chk("force hi", 1, pin_out[0]);
    bus(1'b1, IDX_OMOL, 16'h0002, 4'h1);
    bus(1'b1, IDX_FORCE, 16'h0001, 4'h1);
    chk("force lo", 0, pin_out[0]);
    rdc("force flag", IDX_FLAG, 0);
    bus(1'b1, IDX_PORT, 16'h0001, 4'h1);
    chk("port held", 0, pin_out[0]);
    bus(1'b1, IDX_DIR, 16'h0000, 4'h1);
    chk("port shown", 1, pin_out[0]);
    bus(1'b1, IDX_PORT, 16'h0000, 4'h1);
    $display("test compare done");
    // capture on channel 1 with frozen counter
    cap = 16'h0;
    bus(1'b1, IDX_VAL0 + 6'h2, 16'hBEEF, 4'h3);
    rdc("cap write", IDX_VAL0 + 6'h2, 0);
    bus(1'b1, IDX_IE, 16'h0002, 4'h1);
    bus(1'b1, IDX_PD, 16'h0002, 4'h1);
    for (e = 0; e < 8; e++) begin
      bus(1'b1, IDX_EDGE, 16'(e >> 1) << 2, 4'h1);
      bus(1'b1, IDX_CTL1, 16'h0080, 4'h1);
      bus(1'b1, IDX_FLAG, 16'h0003, 4'h1);
      bus(1'b1, IDX_CTL1, 16'h0000, 4'h1);
      bus(1'b0, IDX_CNT, 16'h0, 4'h3);
      t0 = q[15:0];
      lvl[1] <= ~lvl[1];
      exp_f = (e % 2 == 0) ? e[1] : e[2];
      repeat (12) @(posedge clock);
      rdc("counter hold", IDX_CNT, {16'h0, t0});
      if (exp_f) cap = t0;
      rdc("cap flag", IDX_FLAG, {30'h0, exp_f, 1'b0});
      rdc("cap val", IDX_VAL0 + 6'h2, {16'h0, cap});
      chk("irq", exp_f, chan_irq[1]);
    end
    if (cap == 16'h0) chk("cap seen", 1, 0);
    bus(1'b1, IDX_FLAG, 16'h0002, 4'h1);
    rdc("clr off", IDX_FLAG, 32'h2);
    bus(1'b1, IDX_IE, 16'h0000, 4'h1);
    chk("irq masked", 0, chan_irq[1]);
    bus(1'b1, IDX_CTL1, 16'h0080, 4'h1);
    bus(1'b1, IDX_FLAG, 16'h0002, 4'h1);
    rdc("clr on", IDX_FLAG, 0);
    $display("test capture done");
    // prescaler rates
    for (e = 0; e < 12; e++) begin
      d = (e == 11) ? 255 : ($random(seed) & 255);
      if (e < 8) dv = 1 << e;
      else dv = d + 1;
      bus(1'b1, IDX_CTL2, 16'(e & 7), 4'h1);
      bus(1'b1, IDX_PTPS, 16'(d), 4'h1);
      bus(1'b1, IDX_CTL1, (e < 8) ? 16'h0080 : 16'h0088, 4'h1);
      repeat (300) @(posedge clock);
      bus(1'b0, IDX_CNT, 16'h0, 4'h3);
      t0 = q[15:0];
      repeat (2048) @(posedge clock);
      bus(1'b0, IDX_CNT, 16'h0, 4'h3);
      ex = 2051 / dv;
      cv = q[15:0] - t0;
      chk("tick rate", 1, (cv + 1 >= ex && cv <= ex + 1));
    end
    $display("test prescaler done");
    wrap_up();
  end
endmodule : cctc_timer_bench
